// >>> if_n_defines.svh
// Constants for the IF feedback divider word: offsets, field positions, reset value, limits.
// Operation
// - Address 010 copies word on strobe rise
// - Thirteen-bit divide value for each loop
// - Divider is swallow plus programmable counter
// - Every ratio from 56 to 8191 works
// - Swallow count accepts any value 0-7
// - Transmit sleep bit 15 stops transmit loop
// - Receive sleep bit 1 stops receive loop
// - Don't-care bits change nothing at all
`ifndef IF_N_DEFINES_SVH
`define IF_N_DEFINES_SVH

// ************************************************************
// Word layout
// ************************************************************
`define IFN_WORD_WIDTH 32
`define IFN_ADDR_WIDTH 3
`define IFN_ADDR_VALUE 3'h2
`define IFN_DATA_LSB 3
`define IFN_DONT_CARE_POS 0
`define IFN_RX_SLEEP_POS 1
`define IFN_RX_SWALLOW_POS 2
`define IFN_RX_PROGRAM_POS 5
`define IFN_TX_SLEEP_POS 15
`define IFN_TX_SWALLOW_POS 16
`define IFN_TX_PROGRAM_POS 19

// ************************************************************
// Counter widths and limits
// ************************************************************
`define IFN_SWALLOW_WIDTH 3
`define IFN_PROGRAM_WIDTH 10
`define IFN_RATIO_WIDTH 13
`define IFN_PRESCALE 8
`define IFN_PROGRAM_MIN 10'h003
`define IFN_RATIO_MIN 13'h0038
`define IFN_RATIO_MAX 13'h1fff

// ************************************************************
// Reset value: both loops asleep until the first word arrives
// ************************************************************
`define IFN_WORD_RESET 32'h0004_0010

`endif

// >>> if_n_pkg.sv
// Types shared by the IF feedback divider block.
package if_n_pkg;
	typedef logic [12:0] n_ratio_t;
	typedef logic [2:0] swallow_t;
	typedef logic [9:0] program_t;

	typedef struct packed
	{
		logic sleep;
		swallow_t swallow_count;
		program_t program_count;
	} lane_cfg_s;

	typedef enum logic [1:0]
	{
		DIV_IDLE,
		DIV_SWALLOW,
		DIV_MAIN
	} div_state_e;
endpackage

// >>> divider_if.sv
// Carrier between the configuration logic and one feedback divider.
interface divider_if;
	logic sleep;
	logic [2:0] swallow_count;
	logic [9:0] program_count;
	logic step;
	logic modulus_nine;
	logic n_pulse;

	modport ctrl
	(
		output sleep,
		output swallow_count,
		output program_count,
		output step,
		input modulus_nine,
		input n_pulse
	);

	modport div
	(
		input sleep,
		input swallow_count,
		input program_count,
		input step,
		output modulus_nine,
		output n_pulse
	);
endinterface

// >>> nb_divider.sv
// One dual-modulus feedback divider: swallow counter and programmable counter.
`include "if_n_defines.svh"

module nb_divider
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration and prescaler side
	divider_if.div bus
);
	import if_n_pkg::*;

	div_state_e state_q;
	div_state_e state_d;
	program_t b_q;
	program_t b_d;
	swallow_t a_q;
	swallow_t a_d;
	logic pulse_q;
	logic pulse_d;

	// ************************************************************
	// Counting
	// ************************************************************
	// A period is B prescaler cycles, the first A of them at nine
	wire logic period_end = (b_q <= 10'h001);
	wire logic swallow_end = (a_q <= 3'h1);
	wire logic start_swallow = (bus.swallow_count != 3'h0);
	wire div_state_e reload_state = start_swallow ? DIV_SWALLOW : DIV_MAIN;

	always_comb
	begin
		state_d = state_q;
		b_d = b_q;
		a_d = a_q;
		pulse_d = 1'b0;
		unique case (state_q)
			DIV_IDLE:
			begin
				b_d = bus.program_count;
				a_d = bus.swallow_count;
				if (!bus.sleep)
					state_d = reload_state;
			end
			DIV_SWALLOW, DIV_MAIN:
			begin
				if (bus.step && period_end)
				begin
					pulse_d = 1'b1;
					b_d = bus.program_count;
					a_d = bus.swallow_count;
					state_d = reload_state;
				end
				else if (bus.step)
				begin
					b_d = b_q - 10'h001;
					if (state_q == DIV_SWALLOW)
					begin
						a_d = a_q - 3'h1;
						if (swallow_end)
							state_d = DIV_MAIN;
					end
				end
			end
		endcase
		// Sleep overrides counting at once, whatever the phase
		if (bus.sleep)
		begin
			state_d = DIV_IDLE;
			pulse_d = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= DIV_IDLE;
			b_q <= 10'h000;
			a_q <= 3'h0;
			pulse_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			b_q <= b_d;
			a_q <= a_d;
			pulse_q <= pulse_d;
		end
	end

	assign bus.modulus_nine = (state_q == DIV_SWALLOW);
	assign bus.n_pulse = pulse_q;
endmodule

// >>> if_n_divider_config.sv
// Serial capture of the IF feedback divider word and the two loop dividers.
`include "if_n_defines.svh"

module if_n_divider_config
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Three-wire serial link
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic latch_strobe,
	// Prescaler outputs of the two loops
	input wire logic rx_prescaler_out,
	input wire logic tx_prescaler_out,
	// Receive loop
	output logic rx_loop_sleep,
	output logic rx_modulus_nine,
	output logic rx_n_pulse,
	output if_n_pkg::swallow_t rx_swallow_count,
	output if_n_pkg::program_t rx_program_count,
	output if_n_pkg::n_ratio_t rx_n_value,
	// Transmit loop
	output logic tx_loop_sleep,
	output logic tx_modulus_nine,
	output logic tx_n_pulse,
	output if_n_pkg::swallow_t tx_swallow_count,
	output if_n_pkg::program_t tx_program_count,
	output if_n_pkg::n_ratio_t tx_n_value,
	// Status
	output logic word_loaded
);
	import if_n_pkg::*;

	localparam int LANES = 2;

	// ************************************************************
	// Field decoding
	// ************************************************************
	// Only named fields are picked out, so don't-care bits never reach a divider
	function automatic lane_cfg_s lane_fields(input logic [31:0] word, input logic tx);
		lane_cfg_s cfg;
		int sleep_pos;
		int swallow_pos;
		int program_pos;
		sleep_pos = `IFN_DATA_LSB + (tx ? `IFN_TX_SLEEP_POS : `IFN_RX_SLEEP_POS);
		swallow_pos = `IFN_DATA_LSB + (tx ? `IFN_TX_SWALLOW_POS : `IFN_RX_SWALLOW_POS);
		program_pos = `IFN_DATA_LSB + (tx ? `IFN_TX_PROGRAM_POS : `IFN_RX_PROGRAM_POS);
		cfg.sleep = word[sleep_pos];
		cfg.swallow_count = word[swallow_pos +: `IFN_SWALLOW_WIDTH];
		cfg.program_count = word[program_pos +: `IFN_PROGRAM_WIDTH];
		return cfg;
	endfunction

	// With a prescaler of eight the ratio is B and A side by side
	function automatic n_ratio_t ratio_of(input lane_cfg_s cfg);
		return {cfg.program_count, cfg.swallow_count};
	endfunction

	// ************************************************************
	// Serial edge detection
	// ************************************************************
	logic sclk_prev_q;
	logic strobe_prev_q;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sclk_prev_q <= 1'b0;
			strobe_prev_q <= 1'b0;
		end
		else
		begin
			sclk_prev_q <= serial_clock;
			strobe_prev_q <= latch_strobe;
		end
	end

	wire logic sclk_rise = serial_clock & ~sclk_prev_q;
	wire logic strobe_rise = latch_strobe & ~strobe_prev_q;

	// ************************************************************
	// Shift register
	// ************************************************************
	// Most significant bit arrives first, so the address ends in bits 2:0
	logic [31:0] shift_q;
	logic [31:0] shift_d;

	assign shift_d = sclk_rise ? {shift_q[30:0], serial_data} : shift_q;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			shift_q <= 32'h0000_0000;
		else
			shift_q <= shift_d;
	end

	// ************************************************************
	// Word capture
	// ************************************************************
	logic [31:0] word_q;
	logic [31:0] word_d;
	logic loaded_q;

	// A strobe edge sees the word as it stood before this cycle's clock edge
	wire logic addr_hit = (shift_q[`IFN_ADDR_WIDTH-1:0] == `IFN_ADDR_VALUE);
	wire logic capture = strobe_rise & addr_hit;

	assign word_d = capture ? shift_q : word_q;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			word_q <= `IFN_WORD_RESET;
			loaded_q <= 1'b0;
		end
		else
		begin
			word_q <= word_d;
			loaded_q <= capture;
		end
	end

	assign word_loaded = loaded_q;

	// ************************************************************
	// Lane configuration
	// ************************************************************
	lane_cfg_s cfg [LANES];
	logic [LANES-1:0] prescaler_in;
	logic [LANES-1:0] prescaler_prev_q;

	assign prescaler_in = {tx_prescaler_out, rx_prescaler_out};

	assign cfg[0] = lane_fields(word_q, 1'b0);
	assign cfg[1] = lane_fields(word_q, 1'b1);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			prescaler_prev_q <= '0;
		else
			prescaler_prev_q <= prescaler_in;
	end

	// ************************************************************
	// Dividers
	// ************************************************************
	divider_if lane_bus [LANES] ();
	logic [LANES-1:0] lane_modulus;
	logic [LANES-1:0] lane_pulse;

	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : gen_lane
			// Sleep goes straight from the held word, never through a counter
			assign lane_bus[g].sleep = cfg[g].sleep;
			assign lane_bus[g].swallow_count = cfg[g].swallow_count;
			// Counts below three are the host's to avoid; they are passed unchanged
			assign lane_bus[g].program_count = cfg[g].program_count;
			assign lane_bus[g].step = prescaler_in[g] & ~prescaler_prev_q[g];
			assign lane_modulus[g] = lane_bus[g].modulus_nine;
			assign lane_pulse[g] = lane_bus[g].n_pulse;

			nb_divider u_divider
			(
				.clk(clk),
				.reset(reset),
				.bus(lane_bus[g].div)
			);
		end
	endgenerate

	// ************************************************************
	// Ratio outputs
	// ************************************************************
	n_ratio_t ratio_q [LANES];

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ratio_q[0] <= '0;
			ratio_q[1] <= '0;
		end
		else
		begin
			ratio_q[0] <= ratio_of(cfg[0]);
			ratio_q[1] <= ratio_of(cfg[1]);
		end
	end

	// ************************************************************
	// Output mapping
	// ************************************************************
	assign rx_loop_sleep = word_q[`IFN_DATA_LSB + `IFN_RX_SLEEP_POS];
	assign tx_loop_sleep = word_q[`IFN_DATA_LSB + `IFN_TX_SLEEP_POS];
	assign rx_modulus_nine = lane_modulus[0];
	assign tx_modulus_nine = lane_modulus[1];
	assign rx_n_pulse = lane_pulse[0];
	assign tx_n_pulse = lane_pulse[1];
	assign rx_swallow_count = cfg[0].swallow_count;
	assign tx_swallow_count = cfg[1].swallow_count;
	assign rx_program_count = cfg[0].program_count;
	assign tx_program_count = cfg[1].program_count;
	assign rx_n_value = ratio_q[0];
	assign tx_n_value = ratio_q[1];
endmodule

// >>> if_n_monitor.sv
// Assertions on the ports of the IF divider block.
module if_n_monitor
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Watched ports
	input wire logic latch_strobe,
	input wire logic word_loaded,
	input wire logic rx_loop_sleep,
	input wire logic rx_modulus_nine,
	input wire logic rx_n_pulse,
	input if_n_pkg::swallow_t rx_swallow_count,
	input if_n_pkg::program_t rx_program_count,
	input if_n_pkg::n_ratio_t rx_n_value,
	input wire logic tx_loop_sleep,
	input wire logic tx_modulus_nine,
	input wire logic tx_n_pulse,
	input if_n_pkg::swallow_t tx_swallow_count,
	input if_n_pkg::program_t tx_program_count,
	input if_n_pkg::n_ratio_t tx_n_value
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence rx_idle; rx_loop_sleep [*2]; endsequence
	sequence tx_idle; tx_loop_sleep [*2]; endsequence
	chk_rx_sleep_quiet: assert property (rx_idle |-> !rx_n_pulse && !rx_modulus_nine)
		else $error("rx divider active while asleep");
	chk_tx_sleep_quiet: assert property (tx_idle |-> !tx_n_pulse && !tx_modulus_nine)
		else $error("tx divider active while asleep");
	chk_rx_ratio_sum: assert property (
		$stable(rx_swallow_count) && $stable(rx_program_count)
		|-> rx_n_value == {rx_program_count, rx_swallow_count})
		else $error("rx ratio wrong");
	chk_tx_ratio_sum: assert property (
		$stable(tx_swallow_count) && $stable(tx_program_count)
		|-> tx_n_value == {tx_program_count, tx_swallow_count})
		else $error("tx ratio wrong");
	// Counts and sleep bits may only move when a word is taken
	chk_fields_hold: assert property (
		!$stable({rx_swallow_count, rx_program_count, rx_loop_sleep,
		tx_swallow_count, tx_program_count, tx_loop_sleep}) |-> word_loaded)
		else $error("fields moved without a load");
	chk_load_single: assert property (word_loaded |=> !word_loaded)
		else $error("load pulse too long");
	chk_load_strobe: assert property (
		$rose(word_loaded) |-> $past(latch_strobe) && !$past(latch_strobe, 2))
		else $error("load without strobe rise");
	chk_pulse_single: assert property (rx_n_pulse |=> !rx_n_pulse)
		else $error("rx period pulse too long");
	chk_tx_pulse_single: assert property (tx_n_pulse |=> !tx_n_pulse)
		else $error("tx period pulse too long");
endmodule

bind if_n_divider_config if_n_monitor mon (.clk, .reset, .latch_strobe, .word_loaded,
	.rx_loop_sleep, .rx_modulus_nine, .rx_n_pulse, .rx_swallow_count, .rx_program_count,
	.rx_n_value, .tx_loop_sleep, .tx_modulus_nine, .tx_n_pulse, .tx_swallow_count,
	.tx_program_count, .tx_n_value);

// >>> serial_host.sv
// Host model that shifts words over the three-wire link.
module serial_host
(
	// Clock
	input wire logic clk,
	// Serial link
	output logic serial_clock,
	output logic serial_data,
	output logic latch_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		serial_clock = 0;
		serial_data = 0;
		latch_strobe = 0;
	end
	// Link clock stands still outside a frame
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--)
		begin
			@(posedge clk) #1;
			serial_data = w[i];
			serial_clock = 1;
			@(posedge clk) #1;
			serial_clock = 0;
		end
		@(posedge clk) #1;
		latch_strobe = 1;
		serial_data = ~w[0];
		@(posedge clk) #1;
		latch_strobe = 0;
	endtask
endmodule

// >>> if_n_divider_config_bench.sv
// Self-checking bench for the IF divider block.
module if_n_divider_config_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset, sck, sda, sle, rx_pre, tx_pre;
	logic rx_sl, rx_m9, rx_np, tx_sl, tx_m9, tx_np, word_loaded;
	if_n_pkg::swallow_t rx_a, tx_a;
	if_n_pkg::program_t rx_b, tx_b;
	if_n_pkg::n_ratio_t rx_n, tx_n;
	int error_cnt = 0;
	int checks = 0;
	serial_host host (.clk(clk), .serial_clock(sck), .serial_data(sda), .latch_strobe(sle));
	if_n_divider_config dut (.clk(clk), .reset(reset), .serial_clock(sck), .serial_data(sda),
		.latch_strobe(sle), .rx_prescaler_out(rx_pre), .tx_prescaler_out(tx_pre),
		.rx_loop_sleep(rx_sl), .rx_modulus_nine(rx_m9), .rx_n_pulse(rx_np),
		.rx_swallow_count(rx_a), .rx_program_count(rx_b), .rx_n_value(rx_n),
		.tx_loop_sleep(tx_sl), .tx_modulus_nine(tx_m9), .tx_n_pulse(tx_np),
		.tx_swallow_count(tx_a), .tx_program_count(tx_b), .tx_n_value(tx_n),
		.word_loaded(word_loaded));
	// ****************
	// Helpers
	// ****************
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Prescalers step every second cycle
	initial
	begin
		rx_pre = 0;
		tx_pre = 0;
		forever
		begin
			@(posedge clk) #1;
			rx_pre = ~rx_pre;
			tx_pre = ~tx_pre;
		end
	end
	function automatic logic [31:0] mk(input logic ts, input logic [2:0] ta, input logic [9:0] tb,
		input logic rs, input logic [2:0] ra, input logic [9:0] rb, input logic [3:0] low);
		return {tb, ta, ts, rb, ra, rs, low};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic load(input logic [31:0] w, input logic hit);
		logic seen;
		host.send(w);
		// The load pulse stands only in the cycle right after the strobe edge
		seen = (word_loaded === 1'b1);
		for (int n = 0; n < 4; n++)
		begin
			@(posedge clk) #1;
			if (word_loaded === 1'b1)
				seen = 1;
		end
		chk("loaded", hit, seen);
	endtask
	task automatic all(input logic ts, input int ta, tb, input logic rs, input int ra, rb);
		chk("tx sleep", ts, tx_sl);
		chk("rx sleep", rs, rx_sl);
		chk("tx a", ta, tx_a);
		chk("tx b", tb, tx_b);
		chk("rx a", ra, rx_a);
		chk("rx b", rb, rx_b);
		chk("tx n", 8 * tb + ta, tx_n);
		chk("rx n", 8 * rb + ra, rx_n);
	endtask
	// Steps come every second clock here, so a period is 2B clocks and the nine phase 2A
	task automatic gap(input logic tx, input int exp, input int exp_nine);
		int t0, got, nine;
		t0 = -1;
		got = 0;
		nine = 0;
		for (int n = 0; n < 300 && got == 0; n++)
		begin
			@(posedge clk) #1;
			if ((tx ? tx_np : rx_np) === 1'b1)
				if (t0 < 0)
					t0 = n;
				else
					got = n - t0;
			if (t0 >= 0 && got == 0 && (tx ? tx_m9 : rx_m9) === 1'b1)
				nine++;
		end
		chk("period", exp, got);
		chk("nine cycles", exp_nine, nine);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****************
	// Tests
	// ****************
	task automatic t_reset;
		all(1, 0, 0, 1, 0, 0);
		$display("reset test done");
	endtask
	task automatic t_load;
		load(mk(0, 7, 1023, 0, 1, 3, 4'ha), 1);
		all(0, 7, 1023, 0, 1, 3);
		load(mk(1, 2, 500, 1, 2, 500, 4'h1), 0);
		all(0, 7, 1023, 0, 1, 3);
		$display("load test done");
	endtask
	task automatic t_swallow;
		for (int a = 0; a < 8; a++)
		begin
			load(mk(1, a, 7, 0, a, 7, 4'h2), 1);
			all(1, a, 7, 0, a, 7);
		end
		$display("swallow test done");
	endtask
	task automatic t_div;
		int c;
		load(mk(0, 2, 4, 0, 1, 3, 4'h2), 1);
		gap(0, 6, 2);
		gap(1, 8, 4);
		load(mk(1, 2, 4, 1, 1, 3, 4'h2), 1);
		c = 0;
		repeat (40)
		begin
			@(posedge clk) #1;
			c += (rx_np === 1'b1) + (tx_np === 1'b1);
		end
		chk("asleep pulses", 0, c);
		$display("divider test done");
	endtask
	initial
	begin
		#200000;
		error_cnt++;
		end_sim;
	end
	initial
	begin
		reset = 1;
		repeat (10) @(posedge clk);
		#1 reset = 0;
		t_reset;
		t_load;
		t_swallow;
		t_div;
		end_sim;
	end
endmodule
